// ==== hdl/flash_host_pkg.sv ====
// Constants, operation codes and pin bundles of the parallel flash host controller
package flash_host_pkg;
	// ----------------------------------------------------------------
	// Widths and clock
	// ----------------------------------------------------------------
	localparam int ADDR_W = 21;
	localparam int DATA_W = 8;
	localparam int CNT_W = 16;
	localparam int CLK_PERIOD_NS = 20;
	localparam int SYNC_STAGES = 2;

	// Whole cycles covering a time, never below one
	function automatic int cyc_up(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : cyc_up

	// ----------------------------------------------------------------
	// Timing in ns and derived cycle counts
	// ----------------------------------------------------------------
	localparam int SELECT_ACCESS_NS = 120;
	localparam int RESET_PULSE_MIN_NS = 500;
	localparam int RESET_RELEASE_NS = 50;
	localparam int RESET_COMPLETE_NS = 20000;
	localparam int WRITE_PULSE_NS = 50;
	localparam int WRITE_RECOVER_NS = 30;
	localparam int SELECT_ACCESS_CYC = cyc_up(SELECT_ACCESS_NS);
	localparam int READ_WAIT_CYC = SELECT_ACCESS_CYC + SYNC_STAGES;
	localparam int RESET_PULSE_CYC = cyc_up(RESET_PULSE_MIN_NS);
	localparam int RESET_RELEASE_CYC = cyc_up(RESET_RELEASE_NS);
	localparam int RESET_COMPLETE_CYC = cyc_up(RESET_COMPLETE_NS);
	localparam int WRITE_PULSE_CYC = cyc_up(WRITE_PULSE_NS);
	localparam int WRITE_RECOVER_CYC = cyc_up(WRITE_RECOVER_NS);

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int PROT_SEL_BIT = 6;
	localparam int PROT_A1_BIT = 1;
	localparam int PROT_A0_BIT = 0;
	localparam int STATUS_TOGGLE_BIT = 6;

	typedef enum logic [2:0] {
		OP_READ = 3'h0,
		OP_WRITE = 3'h1,
		OP_RESTART = 3'h2,
		OP_PROTECT = 3'h3,
		OP_UNPROTECT = 3'h4,
		OP_TEMP_WRITE = 3'h5,
		OP_POLL = 3'h6
	} op_t;

	typedef struct packed {
		op_t op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} req_t;

	typedef struct packed {
		logic chip_select_n;
		logic output_gate_n;
		logic write_strobe_n;
		logic hard_restart_n;
		logic high_voltage_level;
	} pins_t;

	localparam pins_t PINS_IDLE = 5'h1e;
endpackage : flash_host_pkg

// ==== hdl/flash_host_ctrl.sv ====
// Host-side pin sequencer for an asynchronous byte-wide parallel flash
// Functional notes
// - Read: select and output gate low, write strobe high; sample data
// - Write: select and write strobe low, output gate high; device latches address/data
// - In short program mode a byte program takes two writes, not four
// - Read from standby is valid only after full select access time
// - Host should reissue a program or erase interrupted by restart
// - Idle restart completes sooner; read only after release-to-read time
// - Protect/unprotect: high voltage, select low, strobe low, A6 choice, A1 high, A0 low
`timescale 1ns/10ps
module flash_host_ctrl #(
	parameter int ADDR_W = flash_host_pkg::ADDR_W,
	parameter int DATA_W = flash_host_pkg::DATA_W
) (
	input wire logic sys_clk_i, // 50 MHz clock
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic req_valid_i, // Request offered
	input wire flash_host_pkg::req_t req_i, // Operation, address, data
	output logic req_ready_o, // Controller idle, request taken
	output logic done_o, // One-cycle completion pulse
	output logic [DATA_W-1:0] rdata_o, // Last byte read
	output logic interrupted_o, // Pulse: restart hit a busy device
	output logic timeout_o, // Pulse: device stayed busy after restart
	output logic [ADDR_W-1:0] address_lines_o, // Flash address pins
	output flash_host_pkg::pins_t ctrl_o, // Flash control pins
	input wire logic [DATA_W-1:0] data_lines_i, // Flash data pins in
	output logic [DATA_W-1:0] data_lines_o, // Flash data pins out
	output logic data_lines_oe_o, // High while host drives data
	input wire logic ready_busy_n_i // Flash ready/busy pin
);
	// ----------------------------------------------------------------
	// Checks and types
	// ----------------------------------------------------------------
	if (ADDR_W != flash_host_pkg::ADDR_W || DATA_W != flash_host_pkg::DATA_W)
	begin : g_width_check
		$error("flash_host_ctrl: widths must match package bundle");
	end

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_READ = 3'h1,
		ST_GAP = 3'h2,
		ST_WRITE = 3'h3,
		ST_WREC = 3'h4,
		ST_RST_LOW = 3'h5,
		ST_RST_WAIT = 3'h6,
		ST_RST_REL = 3'h7
	} state_t;

	function automatic flash_host_pkg::pins_t pins_of(input state_t st, input flash_host_pkg::op_t op);
		flash_host_pkg::pins_t p;
		p = flash_host_pkg::PINS_IDLE;
		case (st)
			ST_READ: {p.chip_select_n, p.output_gate_n} = 2'h0;
			ST_GAP: p.chip_select_n = 1'b0;
			ST_WRITE: {p.chip_select_n, p.write_strobe_n} = 2'h0;
			ST_WREC: p.chip_select_n = 1'b0;
			ST_RST_LOW: p.hard_restart_n = 1'b0;
			default: p = flash_host_pkg::PINS_IDLE;
		endcase
		if ((st == ST_WRITE || st == ST_WREC) && (op == flash_host_pkg::OP_PROTECT ||
			op == flash_host_pkg::OP_UNPROTECT || op == flash_host_pkg::OP_TEMP_WRITE))
			p.high_voltage_level = 1'b1;
		return p;
	endfunction : pins_of

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic rb_meta_reg, rb_sync_reg;
	logic [DATA_W-1:0] data_meta_reg, data_sync_reg;

	always_ff @(posedge sys_clk_i)
	begin
		{rb_sync_reg, rb_meta_reg} <= {rb_meta_reg, ready_busy_n_i};
		{data_sync_reg, data_meta_reg} <= {data_meta_reg, data_lines_i};
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	state_t st_reg, st_next;
	logic [flash_host_pkg::CNT_W-1:0] cnt_reg, cnt_next;
	flash_host_pkg::req_t req_reg, req_next;
	logic first_reg, first_next;
	logic ready_next, done_next, intr_next, tmo_next, oe_next;
	logic [DATA_W-1:0] rdata_next;
	logic [ADDR_W-1:0] addr_next;
	flash_host_pkg::pins_t pins_next;

	always_comb
	begin
		st_next = st_reg;
		cnt_next = (cnt_reg == '0) ? '0 : cnt_reg - 1'b1;
		req_next = req_reg;
		first_next = first_reg;
		{done_next, intr_next, tmo_next} = 3'h0;
		rdata_next = rdata_o;
		case (st_reg)
			ST_IDLE:
			if (req_valid_i && req_ready_o)
			begin
				req_next = req_i;
				first_next = 1'b1;
				case (req_i.op)
					flash_host_pkg::OP_RESTART:
					begin
						st_next = ST_RST_LOW;
						cnt_next = flash_host_pkg::CNT_W'(flash_host_pkg::RESET_PULSE_CYC - 1);
						intr_next = !rb_sync_reg;
					end
					flash_host_pkg::OP_READ, flash_host_pkg::OP_POLL:
					begin
						st_next = ST_READ;
						cnt_next = flash_host_pkg::CNT_W'(flash_host_pkg::READ_WAIT_CYC);
					end
					default:
					begin
						st_next = ST_WRITE;
						cnt_next = flash_host_pkg::CNT_W'(flash_host_pkg::WRITE_PULSE_CYC - 1);
						if (req_i.op == flash_host_pkg::OP_PROTECT || req_i.op == flash_host_pkg::OP_UNPROTECT)
						begin
							req_next.addr[flash_host_pkg::PROT_SEL_BIT] =
								(req_i.op == flash_host_pkg::OP_UNPROTECT);
							req_next.addr[flash_host_pkg::PROT_A1_BIT] = 1'b1;
							req_next.addr[flash_host_pkg::PROT_A0_BIT] = 1'b0;
						end
					end
				endcase
			end
			ST_READ:
			if (cnt_reg == '0)
			begin
				rdata_next = data_sync_reg;
				first_next = 1'b0;
				if (req_reg.op == flash_host_pkg::OP_POLL && (first_reg ||
					data_sync_reg[flash_host_pkg::STATUS_TOGGLE_BIT] !=
					rdata_o[flash_host_pkg::STATUS_TOGGLE_BIT]))
					st_next = ST_GAP;
				else
				begin
					st_next = ST_IDLE;
					done_next = 1'b1;
				end
			end
			ST_GAP:
			begin
				st_next = ST_READ;
				cnt_next = flash_host_pkg::CNT_W'(flash_host_pkg::READ_WAIT_CYC);
			end
			ST_WRITE:
			if (cnt_reg == '0)
			begin
				st_next = ST_WREC;
				cnt_next = flash_host_pkg::CNT_W'(flash_host_pkg::WRITE_RECOVER_CYC - 1);
			end
			ST_RST_LOW:
			if (cnt_reg == '0)
			begin
				st_next = ST_RST_WAIT;
				cnt_next = flash_host_pkg::CNT_W'(flash_host_pkg::RESET_COMPLETE_CYC - 1);
			end
			ST_RST_WAIT:
			if (rb_sync_reg || cnt_reg == '0)
			begin
				st_next = ST_RST_REL;
				tmo_next = !rb_sync_reg;
				cnt_next = flash_host_pkg::CNT_W'(flash_host_pkg::RESET_RELEASE_CYC - 1);
			end
			ST_WREC, ST_RST_REL:
			if (cnt_reg == '0)
			begin
				st_next = ST_IDLE;
				done_next = 1'b1;
			end
			default: st_next = ST_IDLE;
		endcase
		ready_next = (st_next == ST_IDLE);
		pins_next = pins_of(st_next, req_next.op);
		oe_next = (st_next == ST_WRITE || st_next == ST_WREC);
		// Address held between accesses so the device can sleep
		addr_next = (st_next == ST_IDLE || st_next == ST_RST_LOW) ? address_lines_o : req_next.addr;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			st_reg <= ST_IDLE;
			{cnt_reg, req_reg, first_reg, done_o, interrupted_o, timeout_o} <= '0;
			{rdata_o, address_lines_o, data_lines_o, data_lines_oe_o} <= '0;
			req_ready_o <= 1'b1;
			ctrl_o <= flash_host_pkg::PINS_IDLE;
		end
		else
		begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			req_reg <= req_next;
			first_reg <= first_next;
			req_ready_o <= ready_next;
			{done_o, interrupted_o, timeout_o} <= {done_next, intr_next, tmo_next};
			rdata_o <= rdata_next;
			address_lines_o <= addr_next;
			ctrl_o <= pins_next;
			data_lines_o <= req_next.data;
			data_lines_oe_o <= oe_next;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	logic [flash_host_pkg::CNT_W-1:0] acc_cnt_reg, acc_cnt_next, rlow_cnt_reg, rlow_cnt_next;
	logic [flash_host_pkg::CNT_W-1:0] rel_cnt_reg, rel_cnt_next;

	always_comb
	begin
		acc_cnt_next = (!ctrl_o.chip_select_n && !ctrl_o.output_gate_n) ? acc_cnt_reg + 1'b1 : '0;
		rlow_cnt_next = !ctrl_o.hard_restart_n ? rlow_cnt_reg + 1'b1 : '0;
		rel_cnt_next = !ctrl_o.hard_restart_n ? '0 : (&rel_cnt_reg ? rel_cnt_reg : rel_cnt_reg + 1'b1);
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			{acc_cnt_reg, rlow_cnt_reg} <= '0;
			rel_cnt_reg <= '1;
		end
		else
		begin
			{acc_cnt_reg, rlow_cnt_reg, rel_cnt_reg} <= {acc_cnt_next, rlow_cnt_next, rel_cnt_next};
		end
	end

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	read_pins_a: assert property (st_reg == ST_READ |-> !ctrl_o.chip_select_n &&
		!ctrl_o.output_gate_n && ctrl_o.write_strobe_n && !data_lines_oe_o)
		else $error("read pin levels wrong");
	write_pins_a: assert property (st_reg == ST_WRITE |-> !ctrl_o.chip_select_n &&
		ctrl_o.output_gate_n && !ctrl_o.write_strobe_n && data_lines_oe_o)
		else $error("write pin levels wrong");
	no_contention_a: assert property (data_lines_oe_o |-> ctrl_o.output_gate_n)
		else $error("host drives data while output gate low");
	read_access_a: assert property (st_reg == ST_READ && cnt_reg == '0 |->
		acc_cnt_reg >= flash_host_pkg::CNT_W'(flash_host_pkg::READ_WAIT_CYC))
		else $error("read sampled before select access time");
	restart_pulse_a: assert property ($rose(ctrl_o.hard_restart_n) |->
		rlow_cnt_reg >= flash_host_pkg::CNT_W'(flash_host_pkg::RESET_PULSE_CYC))
		else $error("restart pulse too short");
	restart_quiet_a: assert property (!ctrl_o.hard_restart_n |-> ctrl_o.chip_select_n &&
		ctrl_o.write_strobe_n && !data_lines_oe_o)
		else $error("access during restart");
	release_read_a: assert property ($fell(ctrl_o.chip_select_n) |->
		rel_cnt_reg >= flash_host_pkg::CNT_W'(flash_host_pkg::RESET_RELEASE_CYC))
		else $error("access too soon after restart release");
	busy_wait_a: assert property (st_reg == ST_RST_WAIT && !rb_sync_reg && cnt_reg != '0 |=>
		st_reg == ST_RST_WAIT && !done_o)
		else $error("left restart wait while busy");
	protect_addr_a: assert property (st_reg == ST_WRITE && ctrl_o.high_voltage_level &&
		req_reg.op != flash_host_pkg::OP_TEMP_WRITE |-> address_lines_o[1:0] == 2'h2 &&
		address_lines_o[6] == (req_reg.op == flash_host_pkg::OP_UNPROTECT))
		else $error("protect address pattern wrong");
	qualifier_a: assert property (ctrl_o.high_voltage_level |-> ctrl_o.output_gate_n &&
		ctrl_o.hard_restart_n)
		else $error("high voltage qualifier outside a write");

	read_done_c: cover property (st_reg == ST_READ ##[1:20] done_o);
	poll_repeat_c: cover property (st_reg == ST_GAP ##[1:20] st_reg == ST_GAP);
	restart_busy_c: cover property (interrupted_o ##[1:1000] done_o);
	protect_c: cover property (st_reg == ST_WRITE && ctrl_o.high_voltage_level);
endmodule : flash_host_ctrl

// ==== tb/flash_dev_model.sv ====
// Behavioural byte-wide flash device on the far side of the host controller
`timescale 1ns/10ps
module flash_dev_model #(
	parameter logic [7:0] ID_CODE = 8'h5a, // Arbitrary value
	parameter int BUSY_CYC = 100,
	parameter int RST_CYC = 50,
	parameter logic [7:0] ID_CMD = 8'h21, // Arbitrary command codes
	parameter logic [7:0] EXIT_CMD = 8'h22,
	parameter logic [7:0] PROG_CMD = 8'h23,
	parameter logic [7:0] ERASE_CMD = 8'h24
) (
	input wire logic clk_i, // Model timing clock
	input wire logic [20:0] address_lines_i, // Address pins
	input wire flash_host_pkg::pins_t ctrl_i, // Control pins
	input wire logic [7:0] data_lines_i, // Resolved data bus
	output logic [7:0] data_lines_o, // Device drive
	output logic ready_busy_n_o // Low while busy
);
	logic [7:0] mem [256];
	logic [7:0] prog_data;
	logic [20:0] lat_addr;
	logic [7:0] lat_data;
	logic lat_hv, id_mode, armed, busy, ers, tgl, ws_q, rd_q, rd_en;
	int cnt;
	assign rd_en = !ctrl_i.chip_select_n && !ctrl_i.output_gate_n && ctrl_i.write_strobe_n
		&& ctrl_i.hard_restart_n;
	assign ready_busy_n_o = !(busy || cnt != 0);

	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'h3c;
		{data_lines_o, id_mode, armed, busy, ers, tgl, cnt} = '0;
		{ws_q, rd_q, lat_hv, lat_addr} = '0;
	end

	// Released bus shows the inverse; data stays held while read-enabled (select and output gate low, write strobe and restart high)
	always @(rd_en)
	begin
		data_lines_o = ~data_lines_o;
		if (rd_en)
		begin
			#(flash_host_pkg::SELECT_ACCESS_NS);
			if (rd_en)
				data_lines_o = busy ? {~prog_data[7], tgl, 6'h00}
					: (id_mode ? ID_CODE : mem[address_lines_i[7:0]]);
		end
	end

	// Pins sampled on the falling edge, clear of the host's launch edge
	always @(negedge clk_i)
	begin
		if (!ctrl_i.hard_restart_n)
		begin
			if (busy)
				cnt = RST_CYC;
			{busy, ers, id_mode, armed} = 4'h0;
		end
		else if (cnt > 0)
		begin
			cnt = cnt - 1;
			if (busy && cnt == 0)
			begin
				for (int i = 0; i < 256; i++)
					if (ers && i[7:4] == lat_addr[7:4])
						mem[i] = 8'hff;
				if (!ers)
					mem[lat_addr[7:0]] = prog_data;
				{busy, ers} = 2'h0;
			end
		end
		if (!ws_q && ctrl_i.write_strobe_n && !ctrl_i.chip_select_n && ctrl_i.hard_restart_n
			&& !busy)
		begin
			lat_addr = address_lines_i;
			lat_data = data_lines_i;
			lat_hv = ctrl_i.high_voltage_level;
			if (armed)
				{prog_data, busy, cnt, armed} = {lat_data, 1'b1, BUSY_CYC, 1'b0};
			else if (lat_data == ERASE_CMD)
				{prog_data, ers, busy, cnt} = {8'hff, 1'b1, 1'b1, BUSY_CYC};
			else if (lat_data == ID_CMD)
				id_mode = 1'b1;
			else if (lat_data == EXIT_CMD)
				id_mode = 1'b0;
			else if (lat_data == PROG_CMD)
				armed = 1'b1;
		end
		if (rd_q && !rd_en && busy)
			tgl = ~tgl;
		ws_q = ctrl_i.write_strobe_n;
		rd_q = rd_en;
	end
endmodule : flash_dev_model

// ==== tb/flash_host_ctrl_bench.sv ====
// Self-checking bench for the parallel flash host controller
`timescale 1ns/10ps
module flash_host_ctrl_bench;
	logic sys_clk_i, rst_i, req_valid_i, req_ready_o, done_o, interrupted_o, timeout_o;
	logic data_lines_oe_o, ready_busy_n, irq_seen, tmo_seen;
	logic [7:0] rdata_o, data_lines_o, dev_data, bus;
	logic [20:0] address_lines_o;
	flash_host_pkg::req_t req_i;
	flash_host_pkg::pins_t ctrl_o;
	int err_count;
	int samples_checked;
	localparam logic [7:0] ID_CODE = 8'h5a; // Arbitrary value
	localparam logic [7:0] ID_CMD = 8'h21; // Arbitrary command codes
	localparam logic [7:0] EXIT_CMD = 8'h22;
	localparam logic [7:0] PROG_CMD = 8'h23;
	localparam logic [7:0] ERASE_CMD = 8'h24;
	localparam logic [20:0] CMD_ADDR = 21'h000020;
	assign bus = data_lines_oe_o ? data_lines_o : dev_data;

	flash_host_ctrl dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
		.req_i(req_i), .req_ready_o(req_ready_o), .done_o(done_o), .rdata_o(rdata_o),
		.interrupted_o(interrupted_o), .timeout_o(timeout_o), .address_lines_o(address_lines_o),
		.ctrl_o(ctrl_o), .data_lines_i(bus), .data_lines_o(data_lines_o),
		.data_lines_oe_o(data_lines_oe_o), .ready_busy_n_i(ready_busy_n));
	flash_dev_model #(.ID_CODE(ID_CODE), .ID_CMD(ID_CMD), .EXIT_CMD(EXIT_CMD),
		.PROG_CMD(PROG_CMD), .ERASE_CMD(ERASE_CMD)) dev_u (.clk_i(sys_clk_i),
		.address_lines_i(address_lines_o), .ctrl_i(ctrl_o), .data_lines_i(bus),
		.data_lines_o(dev_data), .ready_busy_n_o(ready_busy_n));

	// ----
	// Helpers
	// ----
	task automatic close_out();
		if (err_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out

	task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic do_op(input flash_host_pkg::op_t op, input logic [20:0] a, input logic [7:0] d);
		int n;
		n = 0;
		{irq_seen, tmo_seen} = 2'b00;
		req_i = '{op: op, addr: a, data: d};
		req_valid_i = 1'b1;
		while (req_ready_o !== 1'b1)
			@(negedge sys_clk_i);
		@(negedge sys_clk_i);
		req_valid_i = 1'b0;
		while (done_o !== 1'b1 && n < 3000)
		begin
			// One-cycle flags; the first may stand right after the take edge
			irq_seen = irq_seen | (interrupted_o === 1'b1);
			tmo_seen = tmo_seen | (timeout_o === 1'b1);
			@(negedge sys_clk_i);
			n++;
		end
		chk("done", 21'h1, {20'h0, done_o});
	endtask : do_op

	task automatic wr(input logic [20:0] a, input logic [7:0] d);
		do_op(flash_host_pkg::OP_WRITE, a, d);
	endtask : wr

	task automatic rd_chk(input string what, input logic [20:0] a, input logic [7:0] exp);
		do_op(flash_host_pkg::OP_READ, a, 8'h00);
		chk(what, {13'h0, exp}, {13'h0, rdata_o});
	endtask : rd_chk

	task automatic prog_poll(input logic [20:0] a, input logic [7:0] d, input logic poll);
		wr(CMD_ADDR, PROG_CMD);
		wr(a, d);
		if (poll)
			do_op(flash_host_pkg::OP_POLL, a, 8'h00);
	endtask : prog_poll

	// ----
	// Scenarios
	// ----
	task automatic t_read_id();
		rd_chk("array read", 21'h000005, 8'h39);
		chk("idle pins", 21'h00001e, {16'h0, ctrl_o});
		wr(CMD_ADDR, ID_CMD);
		rd_chk("id code", 21'h000000, ID_CODE);
		wr(CMD_ADDR, EXIT_CMD);
		rd_chk("array after exit", 21'h000007, 8'h3b);
	endtask : t_read_id

	task automatic t_program();
		prog_poll(21'h000009, 8'hc3, 1'b1);
		chk("poll result", 21'h0000c3, {13'h0, rdata_o});
		rd_chk("programmed byte", 21'h000009, 8'hc3);
	endtask : t_program

	task automatic t_erase();
		wr(21'h000045, ERASE_CMD);
		do_op(flash_host_pkg::OP_POLL, 21'h000045, 8'h00);
		chk("erase poll", 21'h0000ff, {13'h0, rdata_o});
		rd_chk("erased byte", 21'h000041, 8'hff);
		rd_chk("other sector", 21'h000055, 8'h69);
	endtask : t_erase

	task automatic t_protect();
		do_op(flash_host_pkg::OP_PROTECT, 21'h1f0041, 8'h00);
		chk("protect addr", 21'h1f0002, dev_u.lat_addr);
		chk("protect level", 21'h1, {20'h0, dev_u.lat_hv});
		do_op(flash_host_pkg::OP_UNPROTECT, 21'h010000, 8'h00);
		chk("unprotect addr", 21'h010042, dev_u.lat_addr);
		do_op(flash_host_pkg::OP_TEMP_WRITE, 21'h000003, 8'h00);
		chk("temp addr", 21'h000003, dev_u.lat_addr);
		chk("temp level", 21'h1, {20'h0, dev_u.lat_hv});
		wr(21'h000004, 8'h00);
		chk("plain level", 21'h0, {20'h0, dev_u.lat_hv});
	endtask : t_protect

	task automatic t_restart();
		do_op(flash_host_pkg::OP_RESTART, 21'h0, 8'h00);
		chk("idle restart flag", 21'h0, {20'h0, irq_seen});
		prog_poll(21'h00000b, 8'h55, 1'b0);
		do_op(flash_host_pkg::OP_RESTART, 21'h0, 8'h00);
		chk("busy restart flag", 21'h1, {20'h0, irq_seen});
		chk("restart timeout", 21'h0, {20'h0, tmo_seen});
		rd_chk("aborted byte", 21'h00000b, 8'h37);
		prog_poll(21'h00000b, 8'h55, 1'b1);
		rd_chk("reissued byte", 21'h00000b, 8'h55);
	endtask : t_restart

	always @(negedge sys_clk_i)
		if (data_lines_oe_o === 1'b1 && ctrl_o.output_gate_n !== 1'b1)
		begin
			err_count++;
			$display("[FAIL] output gate expected 1 seen %b", ctrl_o.output_gate_n);
		end

	initial
	begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end

	initial
	begin
		#400000;
		err_count++;
		$display("[FAIL] watchdog expected finish seen hang");
		close_out();
	end

	initial
	begin
		{err_count, samples_checked} = '0;
		{rst_i, req_valid_i, irq_seen, tmo_seen} = 4'h8;
		req_i = '0;
		repeat (6) @(negedge sys_clk_i);
		rst_i = 1'b0;
		t_read_id();
		t_program();
		t_erase();
		t_protect();
		t_restart();
		close_out();
	end
endmodule : flash_host_ctrl_bench
